// ### hw/tes_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types of the two-wire EEPROM slave
// ----------------------------------------------------------------------------
package tes_pkg;

   // ----------------------------------------------------------------------------
   // Array organisation
   // ----------------------------------------------------------------------------
   localparam int MEM_BYTES = 8192;
   localparam int ADDR_W = 13;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_W = 5;
   localparam int BYTE_W = 8;
   localparam int ADDR_HI_W = ADDR_W - BYTE_W;

   // ----------------------------------------------------------------------------
   // Slave-select byte layout
   // ----------------------------------------------------------------------------
   localparam int SEL_RW_BIT = 0;
   localparam int SEL_STRAP_LSB = 1;
   localparam int SEL_STRAP_MSB = 3;
   localparam int SEL_TYPE_LSB = 4;
   localparam int SEL_TYPE_MSB = 7;
   // Device type code; the value is arbitrary.
   localparam logic [3:0] DEV_TYPE_DFLT = 4'h5;

   // ----------------------------------------------------------------------------
   // Bit counting
   // ----------------------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] CNT_ONE = 4'h1;

   // ----------------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 20;
   localparam int T_WR_MAX_US = 5000;
   // Longest time; the product is exact, so the count is not rounded.
   localparam int WR_CYCLES_DFLT = T_WR_MAX_US * CLK_FREQ_MHZ;

   // ----------------------------------------------------------------------------
   // Synchronised level inputs: positions in the level vector
   // ----------------------------------------------------------------------------
   localparam int LVL_W = 5;
   localparam int LVL_STRAP_LSB = 0;
   localparam int LVL_STRAP_MSB = 2;
   localparam int LVL_WP = 3;
   localparam int LVL_PGOOD = 4;

   // ----------------------------------------------------------------------------
   // Protocol states
   // ----------------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_SEL,
      ST_AHI,
      ST_ALO,
      ST_WDAT,
      ST_ACK,
      ST_TX,
      ST_MACK,
      ST_WAIT
   } tes_state_t;

endpackage

// ### hw/tes_line_mon.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Bus line monitor: synchronisers, clock edges, Start and Stop
// ----------------------------------------------------------------------------
module tes_line_mon
   import tes_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Raw pins
   input wire logic scl,
   input wire logic sda_i,
   input wire logic [LVL_W-1:0] lvl,
   // Synchronised view
   output logic sda_s,
   output logic [LVL_W-1:0] lvl_s,
   output logic scl_rise,
   output logic scl_fall,
   output logic start,
   output logic stop
);

   typedef struct packed {
      logic [1:0] scl_m;
      logic [1:0] sda_m;
      logic [LVL_W-1:0] lvl_m;
      logic [LVL_W-1:0] lvl_q;
      logic scl_q;
      logic sda_q;
      logic scl_p;
      logic sda_p;
   } tes_mon_t;

   localparam tes_mon_t MON_RST = '{scl_m: 2'h3, sda_m: 2'h3, scl_q: 1'b1, sda_q: 1'b1,
                                    scl_p: 1'b1, sda_p: 1'b1, default: '0};

   tes_mon_t r;
   tes_mon_t next_r;

   // Three stages on clock and data, two on the level inputs, then one more stage on clock and data kept for edge detection.
   always_comb begin
      next_r = r;
      next_r.scl_m = {r.scl_m[0], scl}; // (R26)
      next_r.sda_m = {r.sda_m[0], sda_i}; // (R26)
      next_r.lvl_m = lvl;
      next_r.lvl_q = r.lvl_m;
      next_r.scl_q = r.scl_m[1];
      next_r.sda_q = r.sda_m[1];
      next_r.scl_p = r.scl_q;
      next_r.sda_p = r.sda_q;
   end

   // State register.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= MON_RST;
      end else begin
         r <= next_r;
      end
   end

   // Events are formed only from fully synchronised samples.
   assign sda_s = r.sda_q;
   assign lvl_s = r.lvl_q;
   assign scl_rise = r.scl_q & ~r.scl_p;
   assign scl_fall = ~r.scl_q & r.scl_p;
   assign start = r.scl_q & r.scl_p & r.sda_p & ~r.sda_q; // (R14) (R16)
   assign stop = r.scl_q & r.scl_p & ~r.sda_p & r.sda_q; // (R14) (R18)

endmodule

// ### hw/tes_eeprom.sv
`timescale 1ns/1ps
// Overview of operation
// (R1) Holds 8192 bytes, each eight bits, addressed byte by byte.
// (R2) Pages of 32 bytes; partial page writes leave unsent bytes unchanged.
// (R3) Each write is self timed and ends within 5 ms.
// (R4) Reset ignores the bus, then the controller starts in standby.
// (R5) A falling power-good drops the device into standby.
// (R6) After Stop the device goes to standby unless a write runs.
// (R7) Write protect high blocks all programming; device is read-only.
// (R8) Write protect low lets writes proceed normally.
// (R9) Three address straps let eight devices share a bus.
// (R10) Data line is open drain: pulled low or released, never driven high.
// (R11) The master makes the clock, Start and Stop; device only listens.
// (R12) The master starts a transfer only on an idle bus.
// (R13) Data changes only while the clock is low.
// (R14) A data change while the clock is high is Start or Stop.
// (R15) One data bit per clock pulse, sampled in the high phase.
// (R16) Start is data falling while the clock is high.
// (R17) The device ignores the bus until it sees a Start.
// (R18) Stop is data rising while the clock is high.
// (R19) The master ends every operation with Stop.
// (R20) After Start: select byte, address bytes, then data bytes.
// (R21) Select byte last bit: 1 read, 0 write; three bits match straps.
// (R22) Each received byte is acknowledged low in its ninth clock.
// (R23) Page write advances five low address bits, wraps; programming starts at Stop.
// (R24) Select byte is not acknowledged while the write cycle runs.
// (R25) Thirteen-bit address pointer; higher received address bits ignored.
// (R26) Clock and data are synchronised before edge and Start/Stop detection.
module tes_eeprom
   import tes_pkg::*;
#(
   parameter int unsigned WR_CYCLES = WR_CYCLES_DFLT,
   parameter logic [3:0] DEV_TYPE = DEV_TYPE_DFLT
)
(
   // Clock and power-on reset
   input wire logic clk,
   input wire logic rst_n,
   // Two-wire bus
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // Straps and protection
   input wire logic strap_addr_bit0,
   input wire logic strap_addr_bit1,
   input wire logic strap_addr_bit2,
   input wire logic wp,
   input wire logic power_good,
   // Status
   output logic write_busy,
   output logic standby
);

   // ----------------------------------------------------------------------------
   // Local sizes
   // ----------------------------------------------------------------------------
   localparam int TMR_W = $clog2(WR_CYCLES + 1);
   localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(WR_CYCLES - 1);
   localparam int PIDX_W = PAGE_W + 1;
   localparam int PAGE_NUM_W = ADDR_W - PAGE_W;

   // ----------------------------------------------------------------------------
   // Controller state
   // ----------------------------------------------------------------------------
   typedef struct packed {
      tes_state_t st;
      tes_state_t after_ack;
      logic [3:0] cnt;
      logic [BYTE_W-1:0] shreg;
      logic [ADDR_W-1:0] ptr;
      logic [PAGE_BYTES-1:0] mask;
      logic [PAGE_NUM_W-1:0] page;
      logic prog;
      logic [PIDX_W-1:0] pidx;
      logic [TMR_W-1:0] tmr;
      logic mack;
      logic sda_o;
      logic sda_oe_n;
      logic busy;
      logic standby;
   } tes_core_t;

   localparam tes_core_t CORE_RST = '{st: ST_IDLE, after_ack: ST_IDLE, sda_oe_n: 1'b1,
                                      standby: 1'b1, default: '0};

   tes_core_t r;
   tes_core_t next_r;

   // ----------------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------------
   logic [BYTE_W-1:0] mem [MEM_BYTES]; // (R1)
   logic [BYTE_W-1:0] pbuf [PAGE_BYTES];

   logic mem_we;
   logic [ADDR_W-1:0] mem_addr;
   logic buf_we;
   logic [PAGE_W-1:0] buf_idx;

   // ----------------------------------------------------------------------------
   // Synchronised bus view
   // ----------------------------------------------------------------------------
   logic sda_s;
   logic [LVL_W-1:0] lvl_s;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic wp_s;
   logic pgood_s;
   logic [2:0] strap_s;
   logic [BYTE_W-1:0] rd_byte;
   logic load_tx;

   tes_line_mon u_mon (
      .clk(clk),
      .rst_n(rst_n),
      .scl(scl),
      .sda_i(sda_i),
      .lvl({power_good, wp, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0}),
      .sda_s(sda_s),
      .lvl_s(lvl_s),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start(start),
      .stop(stop)
   );

   // Unpack the synchronised level inputs.
   assign wp_s = lvl_s[LVL_WP];
   assign pgood_s = lvl_s[LVL_PGOOD];
   assign strap_s = lvl_s[LVL_STRAP_MSB:LVL_STRAP_LSB];
   assign rd_byte = mem[r.ptr];

   // ----------------------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------------------

   // True in the states that shift a byte in from the master.
   function automatic logic is_rx(input tes_state_t s);
      is_rx = (s == ST_SEL) || (s == ST_AHI) || (s == ST_ALO) || (s == ST_WDAT);
   endfunction

   // True when the select byte names this device.
   function automatic logic sel_match(input logic [BYTE_W-1:0] b, input logic [2:0] straps);
      sel_match = (b[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE) && (b[SEL_STRAP_MSB:SEL_STRAP_LSB] == straps);
   endfunction

   // A new byte goes out after the select ack of a read or after a master ack.
   assign load_tx = scl_fall && (((r.st == ST_ACK) && (r.after_ack == ST_TX)) || ((r.st == ST_MACK) && r.mack));

   // ----------------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------------
   always_comb begin
      next_r = r;
      mem_we = 1'b0;
      mem_addr = {r.page, r.pidx[PAGE_W-1:0]};
      buf_we = 1'b0;
      buf_idx = r.ptr[PAGE_W-1:0];

      // Self-timed write cycle: copy the sent bytes, then run out the timer.
      if (r.prog) begin
         if (!r.pidx[PAGE_W]) begin
            mem_we = r.mask[r.pidx[PAGE_W-1:0]]; // (R2)
            next_r.pidx = r.pidx + PIDX_W'(1);
         end
         if (r.tmr == TMR_LAST) begin
            next_r.prog = 1'b0; // (R3)
            next_r.busy = 1'b0;
            next_r.mask = '0;
         end else begin
            next_r.tmr = r.tmr + TMR_W'(1);
         end
      end

      // Bus protocol.
      if (start) begin
         next_r.st = ST_SEL; // (R17)
         next_r.cnt = '0;
         next_r.sda_oe_n = 1'b1;
         if (!r.prog) begin
            next_r.mask = '0;
         end
      end else if (stop) begin
         next_r.st = ST_IDLE; // (R6)
         next_r.sda_oe_n = 1'b1;
         if (!r.prog) begin
            if ((|r.mask) && !wp_s) begin
               next_r.prog = 1'b1; // (R23) (R8)
               next_r.busy = 1'b1;
               next_r.pidx = '0;
               next_r.tmr = '0;
            end else begin
               next_r.mask = '0; // (R7)
            end
         end
      end else if (scl_rise) begin
         if (is_rx(r.st) && (r.cnt != BITS_PER_BYTE)) begin
            next_r.shreg = {r.shreg[BYTE_W-2:0], sda_s}; // (R15)
            next_r.cnt = r.cnt + CNT_ONE;
         end else if (r.st == ST_MACK) begin
            next_r.mack = ~sda_s;
         end
      end else if (scl_fall) begin
         case (r.st)
            ST_SEL, ST_AHI, ST_ALO, ST_WDAT: begin
               if (r.cnt == BITS_PER_BYTE) begin
                  next_r.cnt = '0;
                  next_r.sda_oe_n = 1'b0; // (R22) (R10)
                  next_r.st = ST_ACK;
                  case (r.st)
                     ST_SEL: begin
                        if (sel_match(r.shreg, strap_s) && !r.busy) begin // (R9) (R24)
                           next_r.after_ack = r.shreg[SEL_RW_BIT] ? ST_TX : ST_AHI; // (R21) (R20)
                        end else begin
                           next_r.sda_oe_n = 1'b1;
                           next_r.st = ST_WAIT;
                        end
                     end
                     ST_AHI: begin
                        next_r.ptr[ADDR_W-1:BYTE_W] = r.shreg[ADDR_HI_W-1:0]; // (R25)
                        next_r.after_ack = ST_ALO;
                     end
                     ST_ALO: begin
                        next_r.ptr[BYTE_W-1:0] = r.shreg;
                        next_r.after_ack = ST_WDAT;
                     end
                     default: begin
                        buf_we = 1'b1;
                        next_r.mask[r.ptr[PAGE_W-1:0]] = 1'b1;
                        next_r.page = r.ptr[ADDR_W-1:PAGE_W];
                        next_r.ptr[PAGE_W-1:0] = r.ptr[PAGE_W-1:0] + PAGE_W'(1); // (R23)
                        next_r.after_ack = ST_WDAT;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (r.after_ack != ST_TX) begin
                  next_r.sda_oe_n = 1'b1;
                  next_r.st = r.after_ack;
               end
            end
            ST_TX: begin
               if (r.cnt == BITS_PER_BYTE) begin
                  next_r.sda_oe_n = 1'b1;
                  next_r.cnt = '0;
                  next_r.mack = 1'b0;
                  next_r.st = ST_MACK;
               end else begin
                  next_r.shreg = {r.shreg[BYTE_W-2:0], 1'b0};
                  next_r.sda_oe_n = r.shreg[BYTE_W-2]; // (R13)
                  next_r.cnt = r.cnt + CNT_ONE;
               end
            end
            ST_MACK: begin
               if (!r.mack) begin
                  next_r.st = ST_WAIT;
               end
            end
            default: begin
               next_r.st = r.st;
            end
         endcase
      end

      // Shift out the byte at the pointer; the pointer walks the whole array.
      if (load_tx) begin
         next_r.shreg = rd_byte;
         next_r.sda_oe_n = rd_byte[BYTE_W-1]; // (R10)
         next_r.ptr = r.ptr + ADDR_W'(1);
         next_r.cnt = CNT_ONE;
         next_r.st = ST_TX;
      end

      // Loss of power abandons everything but the address pointer, a pending write included.
      if (!pgood_s) begin
         next_r = CORE_RST; // (R5)
         next_r.ptr = r.ptr;
         mem_we = 1'b0;
         buf_we = 1'b0;
      end

      next_r.sda_o = 1'b0; // (R10)
      next_r.standby = (next_r.st == ST_IDLE) && !next_r.busy; // (R6)
   end

   // ----------------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------------

   // Controller state; reset holds the bus in standby.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= CORE_RST; // (R4)
      end else begin
         r <= next_r;
      end
   end

   // Page buffer gathers the bytes of one write.
   always_ff @(posedge clk) begin
      if (buf_we) begin
         pbuf[buf_idx] <= r.shreg;
      end
   end

   // Nonvolatile array, programmed only by the write cycle.
   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[mem_addr] <= pbuf[r.pidx[PAGE_W-1:0]]; // (R1)
      end
   end

   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------
   assign sda_o = r.sda_o;
   assign sda_oe_n = r.sda_oe_n;
   assign write_busy = r.busy;
   assign standby = r.standby;

endmodule

// ### tb/tes_master.sv
`timescale 1ns/1ps
// ------------------
// Bus master model
// ------------------
module tes_master (
   // Link clock
   input wire logic lclk,
   // Bus lines
   input wire logic sda,
   output logic scl,
   output logic sda_rel
);
   // Both lines start released, so the bus is idle.
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   // One bus clock phase, long enough for the slave's synchronisers.
   task automatic half();
      repeat (6) @(posedge lclk);
   endtask

   // Start from an idle bus, or a repeated Start with the clock low.
   task automatic start();
      sda_rel <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_rel <= 1'b0;
      half();
      scl <= 1'b0;
      half();
   endtask

   // Stop: data rises while the clock is high.
   task automatic stop();
      sda_rel <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_rel <= 1'b1;
      half();
   endtask

   // Nine bits, MSB first; returns the line level seen in each high phase.
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_rel <= tx[i];
         half();
         scl <= 1'b1;
         half();
         rx[i] = sda;
         scl <= 1'b0;
         @(posedge lclk);
      end
   endtask
endmodule

// ### tb/tes_props.sv
`timescale 1ns/1ps
// ------------------
// Port checker
// ------------------
module tes_props #(
   parameter int unsigned WR_CYCLES = 100000
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Two-wire bus
   input wire logic scl,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   // Straps and protection
   input wire logic strap_addr_bit0,
   input wire logic strap_addr_bit1,
   input wire logic strap_addr_bit2,
   input wire logic wp,
   input wire logic power_good,
   // Status
   input wire logic write_busy,
   input wire logic standby
);
   int unsigned busy_len;

   // Counts the cycles of the running write cycle.
   always_ff @(posedge clk) begin
      if (!rst_n || !write_busy) begin
         busy_len <= 0;
      end else begin
         busy_len <= busy_len + 1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Reset keeps the bus released and the device in standby.
   rst_quiet_a: assert property (disable iff (1'b0) !rst_n |=> sda_oe_n && standby && !write_busy)
      else $error("outputs not at rest after reset");
   odrain_only_a: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   busy_no_stby_a: assert property (write_busy |-> !standby)
      else $error("standby during write cycle");
   wr_len_max_a: assert property (busy_len <= WR_CYCLES + 2)
      else $error("write cycle too long");
   wr_len_min_a: assert property ($fell(write_busy) && power_good |-> busy_len >= WR_CYCLES - 2)
      else $error("write cycle too short");
   busy_deaf_a: assert property (write_busy |-> sda_oe_n)
      else $error("line pulled during write cycle");
   pgood_stby_a: assert property ($fell(power_good) |-> ##[1:8] (standby && !write_busy))
      else $error("no standby after power loss");
   oe_scl_low_a: assert property ($changed(sda_oe_n) |-> !scl)
      else $error("data changed while clock high");
   ack_hold_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
      else $error("low bit too short");

   // Main scenarios.
   cover property ($rose(write_busy));
   cover property ($fell(sda_oe_n));
   cover property ($fell(power_good));
   cover property ($rose(wp));
endmodule

bind tes_eeprom tes_props #(.WR_CYCLES(WR_CYCLES)) u_tes_props (
   .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
   .strap_addr_bit0(strap_addr_bit0), .strap_addr_bit1(strap_addr_bit1),
   .strap_addr_bit2(strap_addr_bit2), .wp(wp), .power_good(power_good),
   .write_busy(write_busy), .standby(standby)
);

// ### tb/tb_top.sv
`timescale 1ns/1ps
// ------------------
// Testbench
// ------------------
module tb_top;
   import tes_pkg::*;
   localparam int unsigned WR = 400;
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic rst_n = 1'b0;
   logic wp = 1'b0;
   logic power_good = 1'b1;
   logic [2:0] strap = 3'h5;
   logic scl, sda_rel, sda, sda_o, sda_oe_n, write_busy, standby;
   logic [8:0] rx;
   logic [7:0] pg [4] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
   int bad_count = 0;
   int n_checks = 0;

   // Clocks, and the data line with its pull-up.
   always #25 clk = ~clk;
   always #32 lclk = ~lclk;
   assign sda = sda_rel & (sda_oe_n | sda_o);

   tes_eeprom #(.WR_CYCLES(WR), .DEV_TYPE(DEV_TYPE_DFLT)) u_tes_eeprom (
      .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
      .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
      .wp(wp), .power_good(power_good), .write_busy(write_busy), .standby(standby)
   );
   tes_master u_tes_master (.lclk(lclk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Compares the acknowledge bit of the last byte.
   task automatic ack(input logic e);
      check({7'h00, rx[0]}, {7'h00, e});
   endtask

   // Sends one byte with the line released in the ninth clock.
   task automatic send(input logic [7:0] b);
      u_tes_master.xfer({b, 1'b1}, rx);
   endtask

   // Start and select byte.
   task automatic sel(input logic [2:0] st, input logic rw);
      u_tes_master.start();
      send({DEV_TYPE_DFLT, st, rw});
   endtask

   // Select for write and both address bytes.
   task automatic point(input logic [7:0] hi, input logic [7:0] lo);
      sel(strap, 1'b0);
      ack(1'b0);
      send(hi);
      ack(1'b0);
      send(lo);
      ack(1'b0);
   endtask

   // Writes n bytes of pg from the address, then Stop.
   task automatic wr(input logic [7:0] hi, input logic [7:0] lo, input int n);
      point(hi, lo);
      for (int i = 0; i < n; i++) begin
         send(pg[i]);
         ack(1'b0);
      end
      u_tes_master.stop();
   endtask

   // Checks the write cycle flag after a short settle.
   task automatic expect_busy(input logic e);
      repeat (8) @(negedge clk);
      check({7'h00, write_busy}, {7'h00, e});
   endtask

   // Bounded wait for standby.
   task automatic idle();
      int k = 0;
      while (standby !== 1'b1 && k < 4 * WR) begin
         @(negedge clk);
         k++;
      end
      check({7'h00, standby}, 8'h01);
      if (k >= 4 * WR) close_out();
   endtask

   // Reads n bytes at the current pointer, expecting pg from index first onward.
   task automatic rd_cur(input int first, input int n);
      sel(strap, 1'b1);
      ack(1'b0);
      for (int i = 0; i < n; i++) begin
         u_tes_master.xfer({8'hFF, i == n - 1}, rx);
         check(rx[8:1], pg[(first + i) % 4]);
      end
      u_tes_master.stop();
      idle();
   endtask

   // Random read: set the pointer, then read after a repeated Start.
   task automatic rd(input logic [7:0] hi, input logic [7:0] lo, input int first, input int n);
      point(hi, lo);
      rd_cur(first, n);
   endtask

   // Main sequence.
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(negedge clk);
      check({6'h00, write_busy, standby}, 8'h01);
      check({6'h00, sda_oe_n, sda_o}, 8'h02);
      $display("test reset done");
      sel(3'h2, 1'b0);
      ack(1'b1);
      u_tes_master.stop();
      $display("test address match done");
      wr(8'h1F, 8'hE2, 1);
      expect_busy(1'b1);
      idle();
      wr(8'hFF, 8'hFE, 4);
      expect_busy(1'b1);
      sel(strap, 1'b0);
      ack(1'b1);
      u_tes_master.stop();
      expect_busy(1'b1);
      idle();
      rd(8'h1F, 8'hFE, 0, 2);
      rd(8'h1F, 8'hE0, 2, 3);
      $display("test page write done");
      @(posedge clk) wp <= 1'b1;
      wr(8'h1F, 8'hE1, 1);
      expect_busy(1'b0);
      idle();
      rd(8'h1F, 8'hE1, 3, 1);
      @(posedge clk) wp <= 1'b0;
      $display("test protect done");
      // The pointer now stands just past the byte read last, at a byte that holds pg[0].
      rd_cur(0, 1);
      $display("test current read done");
      wr(8'h1F, 8'hE3, 1);
      expect_busy(1'b1);
      @(posedge clk) power_good <= 1'b0;
      repeat (10) @(negedge clk);
      check({6'h00, write_busy, standby}, 8'h01);
      @(posedge clk) power_good <= 1'b1;
      repeat (8) @(negedge clk);
      $display("test power drop done");
      close_out();
   end
endmodule
